// >>> ncoph_regs.sv
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`include "ncoph_defs.svh"
module ncoph_regs
	import ncoph_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic oscTickPin,
	output logic [19:0] phaseAccumulator,
	output logic oscillatorEnable,
	output logic oscillatorOutputEnable,
	output logic oscillatorOutputPolarity,
	output logic pulseFrequencyModeSelect,
	output logic [2:0] pulseWidthSelect,
	input wire logic oscillatorOutputLevel
);
	ncoph_acc_if accBus();
	logic [15:0] step;
	logic [7:0] stepHighBuf;
	logic [7:0] control;
	logic [7:0] clkSel;
	logic ack;
	logic tickMeta;
	logic tickSync;
	logic tickLast;
	logic [1:0] lvlSync;
	ncoph_reg_t sel;
	logic wr;
	logic [7:0] wByte;

	always_comb begin
		unique case (address)
			`NCOPH_OFS_ACC_LOW: sel = NCOPH_R_ACCL;
			`NCOPH_OFS_ACC_HIGH: sel = NCOPH_R_ACCH;
			`NCOPH_OFS_ACC_UPPER: sel = NCOPH_R_ACCU;
			`NCOPH_OFS_STEP_LOW: sel = NCOPH_R_STPL;
			`NCOPH_OFS_STEP_HIGH: sel = NCOPH_R_STPH;
			`NCOPH_OFS_CONTROL: sel = NCOPH_R_CTL;
			`NCOPH_OFS_CLKSEL: sel = NCOPH_R_CLK;
			default: sel = NCOPH_R_NONE;
		endcase
	end

	// One wait cycle, answer on the second edge
	assign waitrequest = (read | write) & ~ack;
	assign wr = write & ack & byteenable[0];
	assign wByte = writedata[7:0];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (read | write) & ~ack;
		end
	end

	// Step high is staged; the low write loads both halves together
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			step <= `NCOPH_RST_STEP;
			stepHighBuf <= 8'(`NCOPH_RST_STEP >> 8);
		end else if (wr && sel == NCOPH_R_STPH) begin
			stepHighBuf <= wByte;
		end else if (wr && sel == NCOPH_R_STPL) begin
			step <= {stepHighBuf, wByte};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			control <= `NCOPH_RST_BYTE;
			clkSel <= `NCOPH_RST_BYTE;
		end else if (wr && sel == NCOPH_R_CTL) begin
			control <= wByte & `NCOPH_CTL_WMASK;
		end else if (wr && sel == NCOPH_R_CLK) begin
			clkSel <= wByte & `NCOPH_CLK_WMASK;
		end
	end

	// Tick pin is asynchronous: two stages before the edge detect
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tickMeta <= 1'b0;
			tickSync <= 1'b0;
			tickLast <= 1'b0;
			lvlSync <= 2'h0;
		end else begin
			tickMeta <= oscTickPin;
			tickSync <= tickMeta;
			tickLast <= tickSync;
			lvlSync <= {lvlSync[0], oscillatorOutputLevel};
		end
	end

	assign accBus.step = step;
	assign accBus.run = control[`NCOPH_CTL_EN];
	assign accBus.wrData = {wByte[3:0], wByte, wByte};
	assign accBus.wrByte = {wr && sel == NCOPH_R_ACCU, wr && sel == NCOPH_R_ACCH,
		wr && sel == NCOPH_R_ACCL};

	ncoph_accum uAccum (
		.clk_sys(clk_sys),
		.rst(rst),
		.tick(tickSync & ~tickLast),
		.port(accBus)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			readdata <= 32'h00000000;
		end else if (read && !ack) begin
			unique case (sel)
				NCOPH_R_ACCL: readdata <= {24'h0, accBus.acc[7:0]};
				NCOPH_R_ACCH: readdata <= {24'h0, accBus.acc[15:8]};
				NCOPH_R_ACCU: readdata <= {28'h0, accBus.acc[19:16]};
				NCOPH_R_STPL: readdata <= {24'h0, step[7:0]};
				NCOPH_R_STPH: readdata <= {24'h0, stepHighBuf};
				NCOPH_R_CTL: readdata <= {24'h0, control[7:6], lvlSync[1], control[4:0]};
				NCOPH_R_CLK: readdata <= {24'h0, clkSel};
				NCOPH_R_NONE: readdata <= 32'h00000000;
			endcase
		end
	end

	assign phaseAccumulator = accBus.acc;
	assign oscillatorEnable = control[`NCOPH_CTL_EN];
	assign oscillatorOutputEnable = control[`NCOPH_CTL_OE];
	assign oscillatorOutputPolarity = control[`NCOPH_CTL_POL];
	assign pulseFrequencyModeSelect = control[`NCOPH_CTL_PFM];
	assign pulseWidthSelect = clkSel[7:5];

	property p_upper_zero;
		@(posedge clk_sys) disable iff (rst)
		read && ack && sel == NCOPH_R_ACCU |-> readdata[31:4] == 28'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
	property p_acc_write;
		@(posedge clk_sys) disable iff (rst)
		wr && sel == NCOPH_R_ACCH |=> accBus.acc[15:8] == $past(wByte);
	endproperty
	a_acc_write: assert property (p_acc_write) else $error("acc high write lost");
	property p_upper_write;
		@(posedge clk_sys) disable iff (rst)
		wr && sel == NCOPH_R_ACCU |=> accBus.acc[19:16] == $past(wByte[3:0]);
	endproperty
	a_upper_write: assert property (p_upper_write) else $error("acc upper write lost");
	property p_low_write;
		@(posedge clk_sys) disable iff (rst)
		wr && sel == NCOPH_R_ACCL |=> accBus.acc[7:0] == $past(wByte);
	endproperty
	a_low_write: assert property (p_low_write) else $error("acc low write lost");
	property p_step_load;
		@(posedge clk_sys) disable iff (rst)
		wr && sel == NCOPH_R_STPL |=> step == {$past(stepHighBuf), $past(wByte)};
	endproperty
	a_step_load: assert property (p_step_load) else $error("step not loaded");
	property p_step_hold;
		@(posedge clk_sys) disable iff (rst)
		wr && sel == NCOPH_R_STPH |=> $stable(step);
	endproperty
	a_step_hold: assert property (p_step_hold) else $error("step changed early");
	property p_accum;
		@(posedge clk_sys) disable iff (rst)
		accBus.run && tickSync && !tickLast && !wr |=>
			accBus.acc == 20'($past(accBus.acc) + {4'h0, $past(step)});
	endproperty
	a_accum: assert property (p_accum) else $error("accumulate wrong");
	property p_idle;
		@(posedge clk_sys) disable iff (rst)
		!accBus.run && !wr |=> $stable(accBus.acc);
	endproperty
	a_idle: assert property (p_idle) else $error("acc moved while off");
	property p_wait;
		@(posedge clk_sys) disable iff (rst)
		(read || write) && !ack |=> !waitrequest || !(read || write);
	endproperty
	a_wait: assert property (p_wait) else $error("no answer");

	// Skips the first edge, where a power-up reset may not have landed yet
	property p_reset_vals;
		@(posedge clk_sys)
		rst && $past(rst) |-> accBus.acc == `NCOPH_RST_ACC && step == `NCOPH_RST_STEP;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");
	property p_stage;
		@(posedge clk_sys) disable iff (rst)
		wr && sel == NCOPH_R_STPH |=> stepHighBuf == $past(wByte);
	endproperty
	a_stage: assert property (p_stage) else $error("step high not staged");
	// A write without its byte lane must leave step, the staged step high byte, control and clock select alone
	property p_refused;
		@(posedge clk_sys) disable iff (rst)
		write && ack && !byteenable[0] |=>
			$stable(step) && $stable(stepHighBuf) && $stable(control) && $stable(clkSel);
	endproperty
	a_refused: assert property (p_refused) else $error("masked write landed");
	property p_read_high;
		@(posedge clk_sys) disable iff (rst)
		read && !ack && sel == NCOPH_R_ACCH |=> readdata == {24'h0, $past(accBus.acc[15:8])};
	endproperty
	a_read_high: assert property (p_read_high) else $error("acc high read wrong");
	property p_read_step;
		@(posedge clk_sys) disable iff (rst)
		read && !ack && sel == NCOPH_R_STPL |=> readdata == {24'h0, $past(step[7:0])};
	endproperty
	a_read_step: assert property (p_read_step) else $error("step low read wrong");
	property p_ctl_mask;
		@(posedge clk_sys) disable iff (rst)
		(control & ~`NCOPH_CTL_WMASK) == 8'h00;
	endproperty
	a_ctl_mask: assert property (p_ctl_mask) else $error("control spare bit set");
	property p_clk_mask;
		@(posedge clk_sys) disable iff (rst)
		(clkSel & ~`NCOPH_CLK_WMASK) == 8'h00;
	endproperty
	a_clk_mask: assert property (p_clk_mask) else $error("clock select spare bit set");

	c_step: cover property (@(posedge clk_sys) wr && sel == NCOPH_R_STPH ##[1:20] wr && sel == NCOPH_R_STPL);
	c_run: cover property (@(posedge clk_sys) accBus.run && tickSync && !tickLast);
	c_wrap: cover property (@(posedge clk_sys) accBus.run && accBus.acc[19] ##1 !accBus.acc[19]);
	c_refused: cover property (@(posedge clk_sys) write && ack && !byteenable[0]);
	c_reset: cover property (@(posedge clk_sys) $fell(rst));
endmodule

// >>> ncoph_defs.svh
`ifndef NCOPH_DEFS_SVH
`define NCOPH_DEFS_SVH
`define NCOPH_OFS_ACC_LOW 4'h0
`define NCOPH_OFS_ACC_HIGH 4'h1
`define NCOPH_OFS_ACC_UPPER 4'h2
`define NCOPH_OFS_STEP_LOW 4'h3
`define NCOPH_OFS_STEP_HIGH 4'h4
`define NCOPH_OFS_CONTROL 4'h5
`define NCOPH_OFS_CLKSEL 4'h6
`define NCOPH_RST_ACC 20'h00000
`define NCOPH_RST_STEP 16'h0001
`define NCOPH_RST_BYTE 8'h00
`define NCOPH_UPPER_MASK 8'h0f
`define NCOPH_CTL_EN 7
`define NCOPH_CTL_OE 6
`define NCOPH_CTL_OUT 5
`define NCOPH_CTL_POL 4
`define NCOPH_CTL_PFM 0
`define NCOPH_CTL_WMASK 8'hd1
`define NCOPH_CLK_WMASK 8'he3
`endif

// >>> ncoph_pkg.sv
package ncoph_pkg;
	typedef enum logic [2:0] {
		NCOPH_R_ACCL, NCOPH_R_ACCH, NCOPH_R_ACCU, NCOPH_R_STPL, NCOPH_R_STPH,
		NCOPH_R_CTL, NCOPH_R_CLK, NCOPH_R_NONE
	} ncoph_reg_t;
endpackage

// >>> ncoph_acc_if.sv
`timescale 1ns/100ps
interface ncoph_acc_if;
	logic [19:0] acc;
	logic [15:0] step;
	logic run;
	logic [19:0] wrData;
	logic [2:0] wrByte;
	modport core(input step, run, wrData, wrByte, output acc);
	modport ctrl(output step, run, wrData, wrByte, input acc);
endinterface

// >>> ncoph_accum.sv
`timescale 1ns/100ps
`include "ncoph_defs.svh"
module ncoph_accum
	import ncoph_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic tick,
	ncoph_acc_if.core port
);
	genvar g;
	logic [19:0] next_sum;
	logic [19:0] next_acc;
	assign next_sum = port.acc + {4'h0, port.step};
	// Per-byte software writes beat accumulation for that byte
	generate
		for (g = 0; g < 3; g++) begin : gByte
			localparam int W = (g == 2) ? 4 : 8;
			assign next_acc[g*8 +: W] = port.wrByte[g] ? port.wrData[g*8 +: W] :
				(port.run && tick) ? next_sum[g*8 +: W] : port.acc[g*8 +: W];
		end
	endgenerate
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			port.acc <= `NCOPH_RST_ACC;
		end else begin
			port.acc <= next_acc;
		end
	end
endmodule

// >>> ncoph_regs_test.sv
`timescale 1ns/100ps
`include "ncoph_defs.svh"
module ncoph_regs_test;
	logic clk_sys = 0;
	logic rst = 1;
	logic [3:0] address = 0;
	logic read = 0;
	logic write = 0;
	logic [31:0] writedata = 0;
	logic [3:0] byteenable = 0;
	logic [31:0] readdata;
	logic waitrequest;
	logic oscTickPin = 0;
	logic outLevel = 0;
	logic [19:0] phaseAccumulator;
	logic oscEn;
	logic oscOe;
	logic oscPol;
	logic oscPfm;
	logic [2:0] pws;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	ncoph_regs i_ncoph_regs(.clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .oscTickPin(oscTickPin), .phaseAccumulator(phaseAccumulator),
		.oscillatorEnable(oscEn), .oscillatorOutputEnable(oscOe),
		.oscillatorOutputPolarity(oscPol), .pulseFrequencyModeSelect(oscPfm),
		.pulseWidthSelect(pws), .oscillatorOutputLevel(outLevel));
	initial begin
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk_sys);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, d};
		byteenable <= be;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 0;
		write <= 0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1, a, d, 4'h1, q);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		logic [31:0] q;
		bus(0, a, 8'h00, 4'h0, q);
		chk(q, {24'h0, exp});
	endtask
	// Slow edges, since the pin goes through a two-stage synchroniser
	task automatic tick();
		@(posedge clk_sys);
		oscTickPin <= 1;
		repeat (6) @(posedge clk_sys);
		oscTickPin <= 0;
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic t_reset_values();
		rd(`NCOPH_OFS_ACC_LOW, 8'h00);
		rd(`NCOPH_OFS_ACC_HIGH, 8'h00);
		rd(`NCOPH_OFS_ACC_UPPER, 8'h00);
		rd(`NCOPH_OFS_STEP_LOW, 8'h01);
		rd(`NCOPH_OFS_STEP_HIGH, 8'h00);
		chk({12'h0, phaseAccumulator}, 32'h0);
	endtask
	task automatic t_acc_bytes();
		wr(`NCOPH_OFS_ACC_LOW, 8'ha5);
		wr(`NCOPH_OFS_ACC_HIGH, 8'h5a);
		wr(`NCOPH_OFS_ACC_UPPER, 8'hff);
		rd(`NCOPH_OFS_ACC_UPPER, 8'h0f);
		rd(`NCOPH_OFS_ACC_HIGH, 8'h5a);
		rd(`NCOPH_OFS_ACC_LOW, 8'ha5);
		chk({12'h0, phaseAccumulator}, 32'hf5aa5);
	endtask
	task automatic t_step_and_add();
		wr(`NCOPH_OFS_STEP_HIGH, 8'h12);
		wr(`NCOPH_OFS_STEP_LOW, 8'h34);
		rd(`NCOPH_OFS_STEP_HIGH, 8'h12);
		rd(`NCOPH_OFS_STEP_LOW, 8'h34);
		tick();
		chk({12'h0, phaseAccumulator}, 32'hf5aa5);
		wr(`NCOPH_OFS_CONTROL, 8'h80);
		tick();
		chk({12'h0, phaseAccumulator}, 32'hf6cd9);
		wr(`NCOPH_OFS_ACC_LOW, 8'hf0);
		wr(`NCOPH_OFS_ACC_HIGH, 8'hff);
		tick();
		chk({12'h0, phaseAccumulator}, 32'h01224);
	endtask
	task automatic t_refused();
		logic [31:0] q;
		wr(4'h7, 8'hff);
		rd(4'h7, 8'h00);
		bus(1, `NCOPH_OFS_ACC_HIGH, 8'h77, 4'h0, q);
		rd(`NCOPH_OFS_ACC_HIGH, 8'h12);
	endtask
	// Spare bits are dropped; output level reads back through its synchroniser
	task automatic t_control();
		wr(`NCOPH_OFS_CONTROL, 8'hff);
		wr(`NCOPH_OFS_CLKSEL, 8'hff);
		rd(`NCOPH_OFS_CONTROL, 8'hd1);
		rd(`NCOPH_OFS_CLKSEL, 8'he3);
		chk({25'h0, oscEn, oscOe, oscPol, oscPfm, pws}, 32'h7f);
		outLevel <= 1;
		repeat (4) @(posedge clk_sys);
		rd(`NCOPH_OFS_CONTROL, 8'hf1);
	endtask
	// A lone high write must not reach the adder until the low write
	task automatic t_staged_step();
		wr(`NCOPH_OFS_STEP_HIGH, 8'h55);
		wr(`NCOPH_OFS_CONTROL, 8'h80);
		tick();
		chk({12'h0, phaseAccumulator}, 32'h00001);
		wr(`NCOPH_OFS_STEP_LOW, 8'h00);
		tick();
		chk({12'h0, phaseAccumulator}, 32'h05501);
	endtask
	task automatic t_second_reset();
		@(posedge clk_sys);
		rst <= 1;
		repeat (3) @(posedge clk_sys);
		rst <= 0;
		t_reset_values();
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 0;
		t_reset_values();
		t_acc_bytes();
		t_step_and_add();
		t_refused();
		t_control();
		t_second_reset();
		t_staged_step();
		test_done();
	end
endmodule
